// *** rtl/swps_regs.vh ***
// constants for the store write port sequencer
`ifndef SWPS_REGS_VH
`define SWPS_REGS_VH

// ----------------------------------------------------------------
// bus transfer type codes
// ----------------------------------------------------------------
`define SWPS_TRANS_IDLE 2'h0
`define SWPS_TRANS_NONSEQ 2'h2
`define SWPS_TRANS_SEQ 2'h3

// ----------------------------------------------------------------
// burst type codes
// ----------------------------------------------------------------
`define SWPS_BURST_SINGLE 3'h0
`define SWPS_BURST_INCR 3'h1
`define SWPS_BURST_INCR4 3'h3

// ----------------------------------------------------------------
// transfer size codes
// ----------------------------------------------------------------
`define SWPS_SIZE_8 3'h0
`define SWPS_SIZE_16 3'h1
`define SWPS_SIZE_32 3'h2
`define SWPS_SIZE_64 3'h3

// ----------------------------------------------------------------
// store kinds
// ----------------------------------------------------------------
`define SWPS_KIND_BYTE 2'h0
`define SWPS_KIND_HALF 2'h1
`define SWPS_KIND_WORD 2'h2
`define SWPS_KIND_MULTI 2'h3

// ----------------------------------------------------------------
// line geometry and limits
// ----------------------------------------------------------------
`define SWPS_LINE_WORDS 5'h08
`define SWPS_MAX_WORDS 5'h10
`define SWPS_INCR4_BEATS 4'h4

`endif

// *** rtl/swps_lane_gen.v ***
// byte strobe generator: a run of bytes starting at a lane
`timescale 1ns/1ps
module swps_lane_gen #(
    parameter LANES = 8
) (
    input wire [2:0] lane_i,
    input wire [3:0] nbytes_i,
    output wire [LANES-1:0] strobe_o
);

    // ----------------------------------------------------------------
    // one strobe bit per lane
    // ----------------------------------------------------------------
    wire [4:0] end_lane;

    assign end_lane = {2'h0, lane_i} + {1'h0, nbytes_i};

    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_lane
            localparam [4:0] LANE = g;
            assign strobe_o[g] = (LANE >= {2'h0, lane_i}) &&
                                 (LANE < end_lane);
        end
    endgenerate

endmodule

// *** rtl/swps_piece_dec.v ***
// decoder of the next piece of a store into one bus burst
`timescale 1ns/1ps
`include "swps_regs.vh"
module swps_piece_dec (
    input wire [1:0] kind_i,
    input wire [31:0] orig_addr_i,
    input wire part_i,
    input wire [31:0] cur_addr_i,
    input wire [4:0] left_i,
    output reg [31:0] addr_o,
    output reg [2:0] size_o,
    output reg [3:0] beats_o,
    output reg [2:0] burst_o,
    output reg [3:0] nbytes_o,
    output reg unal_o,
    output reg [4:0] words_o,
    output reg last_o
);

    reg [4:0] room;
    reg [4:0] n;

    // ----------------------------------------------------------------
    // piece selection
    // ----------------------------------------------------------------
    always @* begin
        room = `SWPS_LINE_WORDS - {2'h0, cur_addr_i[4:2]};
        n = (left_i < room) ? left_i : room; // RULE_21 RULE_22
        addr_o = orig_addr_i;
        size_o = `SWPS_SIZE_8;
        beats_o = 4'h1;
        nbytes_o = 4'h1;
        unal_o = 1'b0;
        words_o = 5'h00;
        last_o = 1'b1;
        case (kind_i)
            `SWPS_KIND_MULTI: begin
                // pieces end at the line end, rest from line base
                addr_o = cur_addr_i; // RULE_08 RULE_10 RULE_12
                words_o = n; // RULE_14 RULE_16 RULE_18 RULE_20
                last_o = (left_i == n);
                if (!cur_addr_i[2] && !n[0]) begin
                    size_o = `SWPS_SIZE_64; // RULE_07 RULE_11 RULE_15
                    beats_o = {1'b0, n[3:1]}; // RULE_19
                    nbytes_o = 4'h8;
                end else begin
                    size_o = `SWPS_SIZE_32; // RULE_05 RULE_09 RULE_13
                    beats_o = n[3:0]; // RULE_17
                    nbytes_o = 4'h4;
                end
            end
            `SWPS_KIND_HALF: begin
                case (orig_addr_i[1:0])
                    2'h1: begin
                        addr_o = {orig_addr_i[31:2], 2'h0}; // RULE_02
                        size_o = `SWPS_SIZE_32;
                        nbytes_o = 4'h2;
                        unal_o = 1'b1; // RULE_04
                    end
                    2'h3: begin
                        addr_o = orig_addr_i + {31'h0, part_i}; // RULE_03
                        last_o = part_i;
                    end
                    default: begin
                        size_o = `SWPS_SIZE_16; // RULE_02 RULE_03
                        nbytes_o = 4'h2;
                    end
                endcase
            end
            `SWPS_KIND_WORD: begin
                last_o = part_i; // RULE_06
                case (orig_addr_i[1:0])
                    2'h1: begin
                        if (!part_i) begin
                            addr_o = {orig_addr_i[31:2], 2'h0};
                            size_o = `SWPS_SIZE_32;
                            nbytes_o = 4'h3;
                            unal_o = 1'b1; // RULE_04
                        end else begin
                            addr_o = orig_addr_i + 32'h3;
                        end
                    end
                    2'h2: begin
                        addr_o = orig_addr_i + {30'h0, part_i, 1'b0};
                        size_o = `SWPS_SIZE_16;
                        nbytes_o = 4'h2;
                    end
                    2'h3: begin
                        if (part_i) begin
                            addr_o = orig_addr_i + 32'h1;
                            size_o = `SWPS_SIZE_32;
                            nbytes_o = 4'h3;
                            unal_o = 1'b1; // RULE_04
                        end
                    end
                    default: begin
                        size_o = `SWPS_SIZE_32;
                        nbytes_o = 4'h4;
                        last_o = 1'b1;
                    end
                endcase
            end
            default: begin
                addr_o = orig_addr_i; // RULE_01
            end
        endcase
        if (beats_o == 4'h1) begin
            burst_o = `SWPS_BURST_SINGLE;
        end else if (beats_o == `SWPS_INCR4_BEATS) begin
            burst_o = `SWPS_BURST_INCR4; // RULE_11 RULE_19
        end else begin
            burst_o = `SWPS_BURST_INCR;
        end
    end

endmodule

// *** rtl/swps_sequencer.v ***
// store write port sequencer: stores into bus bursts on a 64-bit port
//
// Functional notes
// RULE_01 - byte store: one single byte transfer
// RULE_02 - halfword at 0,2,4 single; 1,5 word-wide
// RULE_03 - halfword at 3,7 two bytes; 6 one
// RULE_04 - unaligned flag only on partial word transfers
// RULE_05 - aligned word: single 32-bit, lane half by address
// RULE_06 - unaligned word splits into two transfers
// RULE_07 - two words: even 64-bit single, odd incr pair
// RULE_08 - two words from word 7 split over lines
// RULE_09 - three words: incr burst of 32-bit transfers
// RULE_10 - three words from 6,7 split at line
// RULE_11 - four words: even two 64-bit, odd incr4
// RULE_12 - four words from 5-7 split at line
// RULE_13 - five words from 0-3: incr burst
// RULE_14 - five words from 4-7 split at line
// RULE_15 - six words: even 64-bit burst, word 1 32-bit
// RULE_16 - six words from 3-7 split at line
// RULE_17 - seven words from 0,1: incr burst
// RULE_18 - seven words from 2-7 split at line
// RULE_19 - eight words from 0: incr4 of 64-bit
// RULE_20 - eight words from 1-7 split at line
// RULE_21 - nine words: line part then the rest
// RULE_22 - ten to sixteen words split line by line
// RULE_23 - pieces in order, each finished before next
// RULE_24 - slave writes only strobed byte lanes
`timescale 1ns/1ps
`include "swps_regs.vh"
module swps_sequencer (
    input wire clk_i,
    input wire rst_i,
    input wire req_valid_i,
    output wire req_ready_o,
    input wire [1:0] req_kind_i,
    input wire [31:0] req_addr_i,
    input wire [4:0] req_count_i,
    output reg busy_o,
    output reg done_o,
    output reg error_o,
    input wire hready_i,
    input wire hresp_i,
    output reg [1:0] wr_transfer_type_o,
    output reg [31:0] wr_address_o,
    output reg [2:0] wr_burst_type_o,
    output reg [2:0] wr_transfer_size_o,
    output reg [7:0] wr_byte_strobes_o,
    output reg wr_unaligned_flag_o,
    output wire wr_write_o,
    output reg [3:0] wr_word_index_o
);

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam ST_IDLE = 3'h0;
    localparam ST_LOAD = 3'h1;
    localparam ST_BEAT = 3'h2;
    localparam ST_DRAIN = 3'h3;
    localparam ST_ABORT = 3'h4;

    reg [2:0] state_r;
    reg [1:0] kind_r;
    reg [31:0] orig_addr_r;
    reg part_r;
    reg [31:0] cur_addr_r;
    reg [4:0] left_r;
    reg [3:0] word_base_r;
    reg [3:0] beats_left_r;
    reg piece_last_r;

    wire [31:0] dec_addr;
    wire [2:0] dec_size;
    wire [3:0] dec_beats;
    wire [2:0] dec_burst;
    wire [3:0] dec_nbytes;
    wire dec_unal;
    wire [4:0] dec_words;
    wire dec_last;

    wire is64;
    wire [31:0] next_addr;
    wire [2:0] lane_sel;
    wire [3:0] nbytes_sel;
    wire [7:0] strobe;
    wire [1:0] kind_in;
    wire [4:0] count_in;

    // ----------------------------------------------------------------
    // piece decode and strobe generation
    // ----------------------------------------------------------------
    swps_piece_dec u_dec (
        .kind_i(kind_r),
        .orig_addr_i(orig_addr_r),
        .part_i(part_r),
        .cur_addr_i(cur_addr_r),
        .left_i(left_r),
        .addr_o(dec_addr),
        .size_o(dec_size),
        .beats_o(dec_beats),
        .burst_o(dec_burst),
        .nbytes_o(dec_nbytes),
        .unal_o(dec_unal),
        .words_o(dec_words),
        .last_o(dec_last)
    );

    assign is64 = (wr_transfer_size_o == `SWPS_SIZE_64);
    assign next_addr = wr_address_o + (is64 ? 32'h8 : 32'h4);
    // a partial word sent at the word base starts at its own byte lane
    assign lane_sel = (state_r != ST_LOAD) ? next_addr[2:0] :
                      (dec_unal && !orig_addr_r[1]) ? orig_addr_r[2:0] :
                      dec_addr[2:0]; // RULE_02 RULE_06
    assign nbytes_sel = (state_r == ST_LOAD) ? dec_nbytes :
                        (is64 ? 4'h8 : 4'h4);

    swps_lane_gen #(
        .LANES(8)
    ) u_lane (
        .lane_i(lane_sel),
        .nbytes_i(nbytes_sel),
        .strobe_o(strobe)
    );

    // ----------------------------------------------------------------
    // request intake
    // ----------------------------------------------------------------
    // an aligned word store is handled as a one-word multiple store
    assign kind_in = (req_kind_i == `SWPS_KIND_WORD &&
                      req_addr_i[1:0] == 2'h0) ?
                     `SWPS_KIND_MULTI : req_kind_i; // RULE_05
    // a zero count is taken as one word, counts above 16 as 16
    assign count_in = (req_kind_i != `SWPS_KIND_MULTI ||
                       req_count_i == 5'h00) ? 5'h01 :
                      (req_count_i > `SWPS_MAX_WORDS) ?
                      `SWPS_MAX_WORDS : req_count_i;

    assign req_ready_o = (state_r == ST_IDLE);
    // the port only writes
    assign wr_write_o = 1'b1;

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            kind_r <= `SWPS_KIND_BYTE;
            orig_addr_r <= 32'h0;
            part_r <= 1'b0;
            cur_addr_r <= 32'h0;
            left_r <= 5'h00;
            word_base_r <= 4'h0;
            beats_left_r <= 4'h0;
            piece_last_r <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            error_o <= 1'b0;
            wr_transfer_type_o <= `SWPS_TRANS_IDLE;
            wr_address_o <= 32'h0;
            wr_burst_type_o <= `SWPS_BURST_SINGLE;
            wr_transfer_size_o <= `SWPS_SIZE_8;
            wr_byte_strobes_o <= 8'h00;
            wr_unaligned_flag_o <= 1'b0;
            wr_word_index_o <= 4'h0;
        end else begin
            done_o <= 1'b0;
            error_o <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (req_valid_i) begin
                        kind_r <= kind_in;
                        orig_addr_r <= req_addr_i;
                        cur_addr_r <= {req_addr_i[31:2], 2'h0};
                        left_r <= count_in;
                        part_r <= 1'b0;
                        word_base_r <= 4'h0;
                        busy_o <= 1'b1;
                        state_r <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    // first beat of a piece is always nonsequential
                    wr_transfer_type_o <= `SWPS_TRANS_NONSEQ; // RULE_23
                    wr_address_o <= dec_addr;
                    wr_burst_type_o <= dec_burst;
                    wr_transfer_size_o <= dec_size;
                    wr_byte_strobes_o <= strobe; // RULE_01 RULE_05
                    wr_unaligned_flag_o <= dec_unal; // RULE_04
                    wr_word_index_o <= word_base_r;
                    beats_left_r <= dec_beats - 4'h1;
                    piece_last_r <= dec_last;
                    cur_addr_r <= cur_addr_r + {25'h0, dec_words, 2'h0};
                    left_r <= left_r - dec_words;
                    word_base_r <= word_base_r + dec_words[3:0];
                    part_r <= 1'b1; // RULE_06
                    state_r <= ST_BEAT;
                end
                ST_BEAT: begin
                    if (hresp_i && !hready_i) begin
                        wr_transfer_type_o <= `SWPS_TRANS_IDLE;
                        state_r <= ST_ABORT;
                    end else if (hready_i) begin
                        if (beats_left_r == 4'h0) begin
                            wr_transfer_type_o <= `SWPS_TRANS_IDLE;
                            wr_byte_strobes_o <= 8'h00;
                            wr_unaligned_flag_o <= 1'b0;
                            state_r <= ST_DRAIN; // RULE_23
                        end else begin
                            wr_transfer_type_o <= `SWPS_TRANS_SEQ;
                            wr_address_o <= next_addr; // RULE_09 RULE_13
                            wr_byte_strobes_o <= strobe; // RULE_17
                            wr_word_index_o <= wr_word_index_o +
                                               (is64 ? 4'h2 : 4'h1);
                            beats_left_r <= beats_left_r - 4'h1;
                        end
                    end
                end
                ST_DRAIN: begin
                    // wait for the last data phase of the piece
                    if (hresp_i && !hready_i) begin
                        state_r <= ST_ABORT;
                    end else if (hready_i) begin
                        if (piece_last_r) begin
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                            state_r <= ST_IDLE;
                        end else begin
                            state_r <= ST_LOAD; // RULE_23
                        end
                    end
                end
                ST_ABORT: begin
                    // second cycle of an error answer ends the store
                    wr_transfer_type_o <= `SWPS_TRANS_IDLE;
                    wr_byte_strobes_o <= 8'h00;
                    wr_unaligned_flag_o <= 1'b0;
                    if (hready_i) begin
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                        error_o <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// *** test/swps_monitor.sv ***
// assertion checker bound to the store write port sequencer
`timescale 1ns/1ps
`include "swps_regs.vh"
module swps_seq_monitor (
    input wire clk_i,
    input wire rst_i,
    input wire req_valid_i,
    input wire req_ready_o,
    input wire busy_o,
    input wire done_o,
    input wire error_o,
    input wire hready_i,
    input wire hresp_i,
    input wire [1:0] wr_transfer_type_o,
    input wire [31:0] wr_address_o,
    input wire [2:0] wr_transfer_size_o,
    input wire [7:0] wr_byte_strobes_o,
    input wire wr_unaligned_flag_o,
    input wire [3:0] wr_word_index_o
);
    wire act = wr_transfer_type_o[1];
    wire take = req_valid_i && req_ready_o;
    wire [7:0] full32 = 8'h0f << wr_address_o[2:0];
    wire w32 = wr_transfer_size_o == `SWPS_SIZE_32;
    wire w64 = wr_transfer_size_o == `SWPS_SIZE_64;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_take_to_nonseq: assert property (take |=> busy_o ##1
        wr_transfer_type_o == `SWPS_TRANS_NONSEQ) else $error("no start");
    a_busy_refuses: assert property (busy_o |-> !req_ready_o)
        else $error("ready while busy");
    a_done_bound: assert property (take |-> ##[4:400] done_o)
        else $error("store never done");
    a_error_with_done: assert property (error_o |-> done_o)
        else $error("error without done");
    a_hold_on_wait: assert property (act && !hready_i && !hresp_i |=>
        $stable(wr_address_o) && $stable(wr_byte_strobes_o))
        else $error("address phase changed in wait");
    a_byte_lane: assert property (act && !w32 && !w64 &&
        wr_transfer_size_o == `SWPS_SIZE_8 |->
        wr_byte_strobes_o == 8'h01 << wr_address_o[2:0])
        else $error("byte lane wrong");
    a_word_lanes: assert property (act && w32 &&
        !wr_unaligned_flag_o |-> wr_byte_strobes_o == full32)
        else $error("word lanes wrong");
    a_unal_partial: assert property (act |->
        wr_unaligned_flag_o == (w32 && wr_byte_strobes_o != full32))
        else $error("unaligned flag wrong");
    a_wide_full: assert property (act && w64 |->
        wr_byte_strobes_o == 8'hff && wr_address_o[2:0] == 3'h0)
        else $error("wide beat not full");
    a_seq_step: assert property (act && hready_i ##1
        wr_transfer_type_o == `SWPS_TRANS_SEQ |-> wr_address_o ==
        $past(wr_address_o) + ($past(w64) ? 32'h8 : 32'h4))
        else $error("burst address step wrong");
    a_index_step: assert property (act && hready_i ##1
        wr_transfer_type_o[0] |-> wr_word_index_o ==
        $past(wr_word_index_o) + ($past(w64) ? 4'h2 : 4'h1))
        else $error("word index step wrong");
    a_seq_in_line: assert property (wr_transfer_type_o ==
        `SWPS_TRANS_SEQ |-> wr_address_o[4:0] != 5'h00)
        else $error("burst crossed line");
    a_piece_gap: assert property (act && hready_i && !hresp_i
        ##1 !act |=> !act) else $error("pieces too close");
    c_error: cover property (error_o);
    c_wide_seq: cover property (w64 && wr_transfer_type_o[0]);
    c_unal: cover property (act && wr_unaligned_flag_o);
endmodule

bind swps_sequencer swps_seq_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .busy_o(busy_o),
    .done_o(done_o), .error_o(error_o), .hready_i(hready_i),
    .hresp_i(hresp_i), .wr_transfer_type_o(wr_transfer_type_o),
    .wr_address_o(wr_address_o), .wr_transfer_size_o(wr_transfer_size_o),
    .wr_byte_strobes_o(wr_byte_strobes_o),
    .wr_unaligned_flag_o(wr_unaligned_flag_o),
    .wr_word_index_o(wr_word_index_o));

// *** test/swps_slave_model.sv ***
// bus slave model with wait states and a two-cycle error reply
`timescale 1ns/1ps
module swps_slave_model (
    input wire clk_i,
    input wire rst_i,
    input wire [1:0] trans_i,
    input wire [7:0] byte_store_i,
    input wire stall_i,
    input wire err_i,
    output wire hready_o,
    output wire hresp_o
);
    reg dph_r;
    reg wait_r;
    reg [1:0] err_r;
    reg [7:0] byte_store_r;
    reg [7:0] lanes_r;
    // data phase stretched by one wait or by the first error cycle
    assign hready_o = !(dph_r && wait_r) && err_r != 2'h2;
    assign hresp_o = err_r != 2'h0;
    always @(posedge clk_i) begin
        if (rst_i) begin
            dph_r <= 1'b0;
            wait_r <= 1'b0;
            err_r <= 2'h0;
            lanes_r <= 8'h00;
        end else if (hready_o) begin
            dph_r <= trans_i[1];
            err_r <= (trans_i[1] && err_i) ? 2'h2 : 2'h0;
            wait_r <= trans_i[1] && !err_i && stall_i && ($urandom % 2);
            byte_store_r <= byte_store_i;
            // only strobed lanes count as written
            if (dph_r && !hresp_o) lanes_r <= byte_store_r;
        end else begin
            wait_r <= 1'b0;
            if (err_r == 2'h2) err_r <= 2'h1;
        end
    end
endmodule

// *** test/tb_top.sv ***
// self-checking bench for the store write port sequencer
`timescale 1ns/1ps
`include "swps_regs.vh"
module tb_top;
    localparam [1:0] NS = `SWPS_TRANS_NONSEQ;
    localparam [1:0] SQ = `SWPS_TRANS_SEQ;
    localparam [2:0] SG = `SWPS_BURST_SINGLE;
    localparam [2:0] S16 = `SWPS_SIZE_16;
    localparam [2:0] S32 = `SWPS_SIZE_32;
    localparam [31:0] BASE = 32'h4000_0100;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic [1:0] req_kind_i = 2'h0;
    logic [31:0] req_addr_i = 32'h0;
    logic [4:0] req_count_i = 5'h0;
    logic stall = 1'b0;
    logic err = 1'b0;
    wire req_ready_o, busy_o, done_o, error_o, hready_i, hresp_i;
    wire [1:0] wr_transfer_type_o;
    wire [31:0] wr_address_o;
    wire [2:0] wr_burst_type_o, wr_transfer_size_o;
    wire [7:0] wr_byte_strobes_o;
    wire wr_unaligned_flag_o;
    int fail_count = 0;
    int checks_done = 0;
    logic [48:0] exp_q[$];
    logic [48:0] got;

    always #12.5 clk_i = ~clk_i;

    swps_sequencer dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .req_kind_i(req_kind_i), .req_addr_i(req_addr_i),
        .req_count_i(req_count_i), .busy_o(busy_o), .done_o(done_o),
        .error_o(error_o), .hready_i(hready_i), .hresp_i(hresp_i),
        .wr_transfer_type_o(wr_transfer_type_o), .wr_write_o(),
        .wr_address_o(wr_address_o), .wr_burst_type_o(wr_burst_type_o),
        .wr_transfer_size_o(wr_transfer_size_o), .wr_word_index_o(),
        .wr_byte_strobes_o(wr_byte_strobes_o),
        .wr_unaligned_flag_o(wr_unaligned_flag_o));
    swps_slave_model slv_u (.clk_i(clk_i), .rst_i(rst_i),
        .trans_i(wr_transfer_type_o), .byte_store_i(wr_byte_strobes_o),
        .stall_i(stall), .err_i(err), .hready_o(hready_i),
        .hresp_o(hresp_i));

    task automatic chk(input [63:0] e, input [63:0] g);
        checks_done++;
        if (e !== g) begin
            fail_count++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic put(input [1:0] t, input [31:0] a, input [2:0] b,
                       input [2:0] s, input [7:0] m, input u);
        exp_q.push_back({t, a, b, s, m, u});
    endtask
    task automatic pbyte(input [31:0] a);
        put(NS, a, SG, `SWPS_SIZE_8, 8'h01 << a[2:0], 1'b0);
    endtask
    // one burst inside a line: wide beats only from an even word
    task automatic piece(input [31:0] a, input [4:0] k);
        logic w;
        logic [2:0] b;
        logic [31:0] x;
        w = !a[2] && !k[0];
        b = (k == 1 || (w && k == 2)) ? SG : (k == (w ? 8 : 4)) ?
            `SWPS_BURST_INCR4 : `SWPS_BURST_INCR;
        for (int i = 0; i < (w ? k / 2 : k); i++) begin
            x = a + i * (w ? 8 : 4);
            put(i ? SQ : NS, x, b, w ? `SWPS_SIZE_64 : S32,
                w ? 8'hff : 8'h0f << x[2:0], 1'b0);
        end
    endtask
    task automatic expect_store(input [1:0] k, input [31:0] a,
                                input [4:0] c);
        int n;
        int m;
        logic [31:0] x;
        x = a + (a[1:0] == 2'h2 ? 2 : 1);
        if (k == 2'h0 || (k == 2'h1 && a[1:0] == 2'h3)) begin
            pbyte(a);
            if (k == 2'h1) pbyte(a + 1);
        end else if (k == 2'h1) begin
            put(NS, a[0] ? a - 1 : a, SG, a[0] ? S32 : S16,
                8'h03 << a[2:0], a[0]);
        end else if (k == 2'h2) begin
            case (a[1:0])
            2'h0: put(NS, a, SG, S32, 8'h0f << a[2:0], 1'b0);
            2'h1: put(NS, a - 1, SG, S32, 8'h07 << a[2:0], 1'b1);
            2'h2: put(NS, a, SG, S16, 8'h03 << a[2:0], 1'b0);
            default: pbyte(a);
            endcase
            if (a[1:0] == 2'h1) pbyte(a + 3);
            if (a[1:0] == 2'h2) put(NS, x, SG, S16, 8'h03 << x[2:0], 1'b0);
            if (a[1:0] == 2'h3) put(NS, x, SG, S32, 8'h07 << x[2:0], 1'b1);
        end else begin
            n = c == 0 ? 1 : c > 16 ? 16 : c;
            x = {a[31:2], 2'b00};
            while (n > 0) begin
                m = 8 - x[4:2];
                if (m > n) m = n;
                piece(x, m[4:0]);
                x = x + 4 * m;
                n = n - m;
            end
        end
    endtask
    task automatic store(input [1:0] k, input [31:0] a, input [4:0] c,
                         input e, input poke);
        int t;
        if (k == 2'h3) a[1:0] = 2'b00;
        expect_store(k, a, c);
        if (e) exp_q = exp_q[0:0];
        err = e;
        req_valid_i = 1'b1;
        req_kind_i = k;
        req_addr_i = a;
        req_count_i = c;
        @(posedge clk_i) #2;
        if (poke) begin
            req_kind_i = 2'h0;
            req_addr_i = $urandom;
            repeat (2) @(posedge clk_i);
            #2;
        end
        req_valid_i = 1'b0;
        for (t = 0; t < 400 && done_o !== 1'b1; t++) @(posedge clk_i) #2;
        chk(done_o, 1'b1);
        chk(error_o, e);
        chk(exp_q.size(), 0);
        err = 1'b0;
    endtask
    task automatic sweep(input [4:0] n);
        for (int w = 0; w < 8; w++) store(2'h3, BASE + 4 * w, n, 0, 0);
    endtask
    task automatic endtest(input string s);
        $display("test %s finished", s);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // every accepted address phase is matched against the oldest note
    always @(posedge clk_i) begin
        if (rst_i === 1'b0 && wr_transfer_type_o[1] === 1'b1 &&
            hready_i === 1'b1 && hresp_i === 1'b0) begin
            got = {wr_transfer_type_o, wr_address_o, wr_burst_type_o,
                   wr_transfer_size_o, wr_byte_strobes_o,
                   wr_unaligned_flag_o};
            if (exp_q.size() == 0) chk(64'h0, got);
            else chk(exp_q.pop_front(), got);
        end
    end

    initial begin
        #(25 * 60000);
        fail_count++;
        final_report();
    end

    initial begin
        void'($urandom(32'h68014042));
        repeat (12) @(posedge clk_i);
        #2;
        rst_i = 1'b0;
        for (int i = 0; i < 8; i++) store(0, BASE + i, 0, 0, 0);
        for (int i = 0; i < 8; i++) store(1, BASE + i, 0, 0, 0);
        for (int i = 0; i < 8; i++) store(1, BASE + i, 0, 0, 0);
        for (int i = 0; i < 8; i++) store(2, BASE + i, 0, 0, 0);
        endtest("narrow");
        stall = 1'b1;
        sweep(1);
        sweep(2);
        sweep(3);
        sweep(4);
        sweep(5);
        sweep(6);
        sweep(7);
        sweep(8);
        sweep(9);
        for (int n = 10; n <= 16; n++) sweep(n);
        store(3, BASE + 8, 0, 0, 0);
        store(3, BASE + 4, 20, 0, 0);
        endtest("multiple");
        store(3, BASE + 4, 5, 0, 1);
        store(3, BASE + 28, 9, 1, 0);
        store(3, BASE + 4, 3, 0, 0);
        endtest("refuse and error");
        repeat (40) store($urandom % 4, BASE + $urandom % 64,
                          $urandom % 18, 0, 0);
        endtest("random");
        expect_store(3, BASE, 16);
        req_valid_i = 1'b1;
        req_kind_i = 2'h3;
        req_addr_i = BASE;
        req_count_i = 5'h10;
        @(posedge clk_i) #2;
        req_valid_i = 1'b0;
        repeat (6) @(posedge clk_i);
        #2;
        rst_i = 1'b1;
        @(posedge clk_i) #2;
        rst_i = 1'b0;
        exp_q.delete();
        chk(busy_o, 1'b0);
        chk(req_ready_o, 1'b1);
        store(3, BASE + 20, 6, 0, 0);
        endtest("mid reset");
        final_report();
    end
endmodule
